// ===== guard_group.sv
`timescale 1ns/1ps
module guard_group #(
  parameter logic [31:0] RST = 32'h00000000, // reset value of the group
  parameter logic [31:0] VALID = 32'h00000000 // bits tied to a peripheral
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic set_op,
  input wire logic [31:0] wbits,
  output logic [31:0] prot,
  output logic dbl_set,
  output logic dbl_clr
);
  import guard_pkg::*;

  guard_state_t s_r; // registered state
  guard_state_t s_nxt; // next state
  logic [31:0] hit; // written ones on live bits

  ////////////////////////////////////////////////////////////////////////////
  // next state: one bits act, zero bits and dead bits do nothing
  always_comb begin
    s_nxt = s_r;
    hit = wbits & VALID;
    s_nxt.dbl_set = 1'b0;
    s_nxt.dbl_clr = 1'b0;
    if (wr_en) begin
      if (set_op) begin
        s_nxt.prot = s_r.prot | hit;
        s_nxt.dbl_set = |(hit & s_r.prot);
      end else begin
        s_nxt.prot = s_r.prot & ~hit;
        s_nxt.dbl_clr = |(hit & ~s_r.prot);
      end
    end
  end

  // state register, new value visible on the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{prot: RST, dbl_set: 1'b0, dbl_clr: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prot = s_r.prot;
  assign dbl_set = s_r.dbl_set;
  assign dbl_clr = s_r.dbl_clr;
endmodule

// ===== guard_pkg.sv
package guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus map: each group holds a clear word and a set word
  localparam logic [3:0] GRP0_BASE = 4'h0; // group 0 window, addr[11:8]
  localparam logic [3:0] GRP1_BASE = 4'h1; // group 1 window
  localparam logic [3:0] GRP2_BASE = 4'h2; // group 2 window
  localparam logic [3:0] IRQ_BASE = 4'h3; // interrupt status and mask
  localparam logic [7:0] OFS_CLEAR = 8'h00; // protect_clear_reg offset
  localparam logic [7:0] OFS_SET = 8'h04; // protect_set_reg offset
  localparam logic [7:0] OFS_STATUS = 8'h00; // sticky event status
  localparam logic [7:0] OFS_MASK = 8'h04; // interrupt mask

  ////////////////////////////////////////////////////////////////////////////
  // group 0 bit positions
  localparam int G0_EXT_INT_CTL = 6; // external_interrupt_ctl
  localparam int G0_RT_COUNTER = 5; // real_time_counter
  localparam int G0_WATCHDOG = 4; // watchdog_peripheral
  localparam int G0_CLOCK_GEN = 3; // generic_clock_gen
  localparam int G0_SYS_CTL = 2; // system_controller
  localparam int G0_POWER_MGR = 1; // power_manager
  // group 1 bit positions
  localparam int G1_TRACE_STORE = 6; // program_trace_store
  localparam int G1_PORT_CTL = 3; // port controller
  localparam int G1_FLASH_CTL = 2; // flash_controller
  localparam int G1_DEBUG_UNIT = 1; // debug_service_unit
  // group 2 bit positions
  localparam int G2_TOUCH = 19; // touch_controller
  localparam int G2_DAC = 18; // d_to_a_converter
  localparam int G2_COMPARATOR = 17; // analog_comparator
  localparam int G2_ADC = 16; // a_to_d_converter
  localparam int G2_TIMER0 = 8; // timer_counter 0, instances up to bit 15
  localparam int G2_SERIAL0 = 2; // serial_comm_unit 0, instances up to bit 7
  localparam int G2_EVENT_SYS = 1; // event_system

  ////////////////////////////////////////////////////////////////////////////
  // writable bits and reset values per group
  localparam logic [31:0] G0_VALID = 32'h0000007e; // bits 6..1
  localparam logic [31:0] G1_VALID = 32'h0000004e; // bits 6, 3..1
  localparam logic [31:0] G2_VALID = 32'h000ffffe; // bits 19..1
  localparam logic [31:0] G0_RESET = 32'h00000000; // all unprotected
  localparam logic [31:0] G1_RESET = 32'h00000002; // debug unit protected
  localparam logic [31:0] G2_RESET = 32'h00800000; // bit 23 reads one

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status layout
  localparam int EV_VIOLATION = 0; // write to a protected peripheral
  localparam int EV_DBL_SET = 1; // set of an already protected peripheral
  localparam int EV_DBL_CLR = 2; // clear of an already open peripheral
  localparam int EV_COUNT = 3; // number of events

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic req; // one-cycle peripheral write attempt
    logic [1:0] grp; // group of the target peripheral
    logic [4:0] pos; // bit position of the target peripheral
  } per_req_t;

  typedef struct packed {
    logic ok; // write passed to the peripheral
    logic err; // write discarded, access error
  } per_ans_t;

  typedef struct packed {
    logic [31:0] prot; // protection state of one group
    logic dbl_set; // double protect seen
    logic dbl_clr; // double unprotect seen
  } guard_state_t;

endpackage

// ===== per_source.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// stand-in for the guarded peripherals: one write attempt at a time
module per_source (
  input wire logic hclk,
  output guard_pkg::per_req_t per_req,
  input guard_pkg::per_ans_t per_ans
);
  import guard_pkg::*;

  // quiet request lines from time zero
  initial begin
    per_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse, verdict sampled one cycle after the taking edge
  // caller enters just after a rising edge
  task automatic attempt(input logic [1:0] g, input logic [4:0] p, output per_ans_t a);
    per_req <= '{req: 1'b1, grp: g, pos: p};
    @(posedge hclk);
    // target lines do not keep the last target once idle
    per_req <= '{req: 1'b0, grp: ~g, pos: ~p};
    @(posedge hclk);
    a = per_ans;
  endtask
endmodule

// ===== peripheral_write_protect.sv
`timescale 1ns/1ps
module peripheral_write_protect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input guard_pkg::per_req_t per_req,
  output guard_pkg::per_ans_t per_ans,
  output logic [31:0] prot_g0,
  output logic [31:0] prot_g1,
  output logic [31:0] prot_g2
);
  import guard_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state of the bus slave and the interrupt block
  typedef struct packed {
    logic dph_wr; // write data phase pending
    logic dph_rd; // read wait cycle pending
    logic [11:0] dph_addr; // captured address
    logic [3:0] dph_lanes; // captured byte lanes
    logic [31:0] rdata; // read data register
    logic ready; // hreadyout register
    logic resp; // hresp register, always okay
    logic [EV_COUNT-1:0] status; // sticky events
    logic [EV_COUNT-1:0] mask; // interrupt enables
    logic irq; // interrupt line
  } top_state_t;

  top_state_t s_r; // registered state
  top_state_t s_nxt; // next state

  logic accept; // address phase taken this cycle
  logic [31:0] wbits; // write data on enabled lanes
  logic [2:0] g_wr; // write enable per group
  logic set_op; // write goes to the set word
  logic [31:0] g_prot [3]; // group states
  logic [2:0] g_dbl_set; // double set pulses
  logic [2:0] g_dbl_clr; // double clear pulses
  logic [31:0] rd_val; // read mux output
  logic [EV_COUNT-1:0] events; // event pulses this cycle
  logic [EV_COUNT-1:0] w1c; // status bits cleared by software
  logic irq_wr; // write to the interrupt window
  per_ans_t ans; // filter answer

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes of an access from its size and low address bits
  function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (size)
      3'd0: m = 4'h1 << a; // byte
      3'd1: m = a[1] ? 4'hc : 4'h3; // halfword
      default: m = 4'hf; // word
    endcase
    return m;
  endfunction

  // expand a lane mask to a bit mask
  function automatic logic [31:0] lane_bits(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  // true when the offset names one of the two group words
  function automatic logic is_word(input logic [7:0] ofs);
    // low two bits pick a lane inside the word, not another register
    return ({ofs[7:2], 2'b00} == OFS_CLEAR) || ({ofs[7:2], 2'b00} == OFS_SET);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address phase and write decode
  always_comb begin
    accept = hsel & htrans[1] & hready;
    wbits = hwdata & lane_bits(s_r.dph_lanes);
    set_op = ({s_r.dph_addr[7:2], 2'b00} == OFS_SET);
    g_wr[0] = s_r.dph_wr & (s_r.dph_addr[11:8] == GRP0_BASE) & is_word(s_r.dph_addr[7:0]);
    g_wr[1] = s_r.dph_wr & (s_r.dph_addr[11:8] == GRP1_BASE) & is_word(s_r.dph_addr[7:0]);
    g_wr[2] = s_r.dph_wr & (s_r.dph_addr[11:8] == GRP2_BASE) & is_word(s_r.dph_addr[7:0]);
    irq_wr = s_r.dph_wr & (s_r.dph_addr[11:8] == IRQ_BASE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection groups
  guard_group #(.RST(G0_RESET), .VALID(G0_VALID)) u_grp0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(g_wr[0]),
    .set_op(set_op),
    .wbits(wbits),
    .prot(g_prot[0]),
    .dbl_set(g_dbl_set[0]),
    .dbl_clr(g_dbl_clr[0])
  );

  guard_group #(.RST(G1_RESET), .VALID(G1_VALID)) u_grp1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(g_wr[1]),
    .set_op(set_op),
    .wbits(wbits),
    .prot(g_prot[1]),
    .dbl_set(g_dbl_set[1]),
    .dbl_clr(g_dbl_clr[1])
  );

  guard_group #(.RST(G2_RESET), .VALID(G2_VALID)) u_grp2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(g_wr[2]),
    .set_op(set_op),
    .wbits(wbits),
    .prot(g_prot[2]),
    .dbl_set(g_dbl_set[2]),
    .dbl_clr(g_dbl_clr[2])
  );

  ////////////////////////////////////////////////////////////////////////////
  // peripheral write check
  write_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(per_req),
    .prot0(g_prot[0]),
    .prot1(g_prot[1]),
    .prot2(g_prot[2]),
    .ans(ans)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux: both words of a group show the same state
  always_comb begin
    rd_val = 32'h00000000; // unmapped reads as zero
    case (s_r.dph_addr[11:8])
      GRP0_BASE: if (is_word(s_r.dph_addr[7:0])) rd_val = g_prot[0];
      GRP1_BASE: if (is_word(s_r.dph_addr[7:0])) rd_val = g_prot[1];
      GRP2_BASE: if (is_word(s_r.dph_addr[7:0])) rd_val = g_prot[2];
      IRQ_BASE: begin
        if (s_r.dph_addr[7:0] == OFS_STATUS) begin
          rd_val = {29'h0, s_r.status};
        end else if (s_r.dph_addr[7:0] == OFS_MASK) begin
          rd_val = {29'h0, s_r.mask};
        end
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, event status and interrupt
  always_comb begin
    s_nxt = s_r;
    events = '0;
    events[EV_VIOLATION] = ans.err;
    events[EV_DBL_SET] = |g_dbl_set;
    events[EV_DBL_CLR] = |g_dbl_clr;
    w1c = '0;
    // data phase of a write ends this cycle
    if (s_r.dph_wr) begin
      s_nxt.dph_wr = 1'b0;
      if (irq_wr && s_r.dph_addr[7:0] == OFS_STATUS) begin
        w1c = wbits[EV_COUNT-1:0];
      end
      if (irq_wr && s_r.dph_addr[7:0] == OFS_MASK) begin
        // mask bits live in lane 0; a written zero must clear an enable
        s_nxt.mask = s_r.dph_lanes[0] ? hwdata[EV_COUNT-1:0] : s_r.mask;
      end
    end
    // read wait cycle: load data and release the bus
    if (s_r.dph_rd) begin
      s_nxt.dph_rd = 1'b0;
      s_nxt.rdata = rd_val;
      s_nxt.ready = 1'b1;
    end
    // new address phase
    if (accept) begin
      s_nxt.dph_addr = haddr[11:0];
      s_nxt.dph_lanes = lane_mask(hsize, haddr[1:0]);
      if (hwrite) begin
        s_nxt.dph_wr = 1'b1;
      end else begin
        s_nxt.dph_rd = 1'b1;
        s_nxt.ready = 1'b0;
      end
    end
    // set wins over software clear
    s_nxt.status = (s_r.status & ~w1c) | events;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    s_nxt.resp = 1'b0;
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{dph_wr: 1'b0, dph_rd: 1'b0, dph_addr: 12'h000, dph_lanes: 4'h0, rdata: 32'h00000000,
               ready: 1'b1, resp: 1'b0, status: '0, mask: '0, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp = s_r.resp;
  assign irq = s_r.irq;
  assign per_ans = ans;
  assign prot_g0 = g_prot[0];
  assign prot_g1 = g_prot[1];
  assign prot_g2 = g_prot[2];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic any_wr_q; // some group was written since reset
  logic hit_now; // looked-up protection of the current request

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_wr_q <= 1'b0;
    end else if (|g_wr) begin
      any_wr_q <= 1'b1;
    end
  end

  always_comb begin
    case (per_req.grp)
      2'd0: hit_now = g_prot[0][per_req.pos];
      2'd1: hit_now = g_prot[1][per_req.pos];
      2'd2: hit_now = g_prot[2][per_req.pos];
      default: hit_now = 1'b0;
    endcase
  end

  a_reset_values: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !any_wr_q |-> (g_prot[0] == G0_RESET) && (g_prot[1] == G1_RESET) && (g_prot[2] == G2_RESET))
    else $error("group state differs from reset value before any write");

  a_clear_removes: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (g_wr[1] && !set_op) |=> ((g_prot[1] & $past(wbits) & G1_VALID) == 32'h0))
    else $error("clear write left a protection bit set");

  a_set_enables: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (g_wr[2] && set_op) |=> ((g_prot[2] & $past(wbits) & G2_VALID) == ($past(wbits) & G2_VALID)))
    else $error("set write did not protect");

  a_zero_keeps: assert property (
    @(posedge hclk) disable iff (!hresetn)
    g_wr[0] |=> ((g_prot[0] & ~$past(wbits)) == ($past(g_prot[0]) & ~$past(wbits))))
    else $error("zero bit changed protection");

  a_lane_isolate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (g_wr[2] && s_r.dph_lanes == 4'h2) |=> ((g_prot[2] & 32'hffff00ff) == ($past(g_prot[2]) & 32'hffff00ff)))
    else $error("byte write touched another lane");

  a_dead_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((g_prot[0] & ~G0_VALID) == (G0_RESET & ~G0_VALID)) && ((g_prot[2] & ~G2_VALID) == (G2_RESET & ~G2_VALID)))
    else $error("unnamed bit changed");

  a_guard_reject: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (per_req.req && hit_now) |=> (per_ans.err && !per_ans.ok))
    else $error("write to protected peripheral not rejected");

  a_guard_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (per_req.req && !hit_now) |=> (per_ans.ok && !per_ans.err))
    else $error("write to open peripheral rejected");

  a_double_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (g_wr[0] && set_op && |(wbits & G0_VALID & g_prot[0])) |=> ##1 s_r.status[EV_DBL_SET])
    else $error("double protect not flagged");

  a_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite) |=> !hreadyout ##1 (hreadyout && hresp == 1'b0))
    else $error("read did not finish after one wait cycle");

  a_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == |(s_r.status & s_r.mask))
    else $error("interrupt line disagrees with status and mask");

  a_write_no_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && hwrite) |=> hreadyout)
    else $error("write data phase was stretched");

  a_set_wins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (events != 3'h0) |=> ((s_r.status & $past(events)) == $past(events)))
    else $error("event did not reach the status word");

  a_status_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (w1c != 3'h0 && events == 3'h0) |=> ((s_r.status & $past(w1c)) == 3'h0))
    else $error("written one did not clear the status bit");

  a_mask_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (irq_wr && s_r.dph_addr[7:0] == OFS_MASK && s_r.dph_lanes[0])
      |=> ({29'h0, s_r.mask} == ($past(hwdata) & 32'h00000007)))
    else $error("mask write did not land");

  a_dbl_clr_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (g_wr[1] && !set_op && |(wbits & G1_VALID & ~g_prot[1])) |=> ##1 s_r.status[EV_DBL_CLR])
    else $error("double unprotect not flagged");

  a_filter_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !per_req.req |=> (!per_ans.ok && !per_ans.err))
    else $error("verdict without an attempt");

  c_set_write: cover property (@(posedge hclk) disable iff (!hresetn) g_wr[1] && set_op);
  c_dbl_clr: cover property (@(posedge hclk) disable iff (!hresetn) events[EV_DBL_CLR]);
  c_reject: cover property (@(posedge hclk) disable iff (!hresetn) per_ans.err);
  c_byte_write: cover property (@(posedge hclk) disable iff (!hresetn) |g_wr && s_r.dph_lanes == 4'h2);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule

// ===== peripheral_write_protect_test.sv
`timescale 1ns/1ps
module peripheral_write_protect_test;
  import guard_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq; // bus and event lines
  logic [31:0] haddr, hwdata, hrdata, prot_g0, prot_g1, prot_g2; // words
  logic [1:0] htrans; // transfer kind
  logic [2:0] hsize; // access width
  per_req_t per_req; // attempt from the peripheral side
  per_ans_t per_ans; // verdict to the peripheral side
  int failures, n_checks; // mismatch and comparison counts
  integer seed; // random seed
  logic [31:0] exp_p [3]; // expected protection per group
  logic [2:0] exp_st, exp_mask; // expected status and mask
  logic [31:0] v; // scratch for valid bits
  int g, p; // scratch group and position
  logic [2:0] s; // scratch size
  logic [1:0] lo; // scratch byte offset

  peripheral_write_protect dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .per_req(per_req), .per_ans(per_ans), .prot_g0(prot_g0), .prot_g1(prot_g1),
    .prot_g2(prot_g2));

  per_source src (.hclk(hclk), .per_req(per_req), .per_ans(per_ans));

  // 100 ns clock
  always #50 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] valid_of(input int k);
    return (k == 0) ? G0_VALID : (k == 1) ? G1_VALID : G2_VALID;
  endfunction

  function automatic logic [31:0] reset_of(input int k);
    return (k == 0) ? G0_RESET : (k == 1) ? G1_RESET : G2_RESET;
  endfunction

  // byte lanes touched by an access
  function automatic logic [31:0] lanes(input logic [1:0] o, input logic [2:0] z);
    case (z)
      3'h0: return 32'h000000ff << (8 * o);
      3'h1: return 32'h0000ffff << (16 * o[1]);
      default: return 32'hffffffff;
    endcase
  endfunction

  function automatic logic [31:0] prot_of(input int k);
    return (k == 0) ? prot_g0 : (k == 1) ? prot_g1 : prot_g2;
  endfunction

  function automatic logic [31:0] reg_addr(input int k, input logic [7:0] ofs);
    return {20'h0, k[3:0], ofs};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparison and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer; address phase held until hready, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] z, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= z;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, 3'h2, d, r);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 3'h2, 32'h0, r);
    chk(r, exp);
  endtask

  // protection write with model update and double-write bookkeeping
  task automatic grp_wr(input int k, input logic set, input logic [1:0] o, input logic [2:0] z, input logic [31:0] d);
    logic [31:0] eff, r;
    eff = d & lanes(o, z) & valid_of(k);
    if (set && (eff & exp_p[k]) != 32'h0) exp_st[EV_DBL_SET] = 1'b1;
    if (!set && (eff & ~exp_p[k]) != 32'h0) exp_st[EV_DBL_CLR] = 1'b1;
    exp_p[k] = set ? (exp_p[k] | eff) : (exp_p[k] & ~eff);
    bus(1'b1, reg_addr(k, set ? OFS_SET : OFS_CLEAR) | {30'h0, o}, z, d, r);
  endtask

  // both words and the state port
  task automatic grp_chk(input int k);
    rdchk(reg_addr(k, OFS_CLEAR), exp_p[k]);
    rdchk(reg_addr(k, OFS_SET), exp_p[k]);
    chk(prot_of(k), exp_p[k]);
  endtask

  // peripheral attempt; err expected exactly when the target is protected
  task automatic try(input int k, input int q);
    per_ans_t a;
    logic e;
    e = 1'b0;
    if (k < 3) e = exp_p[k][q];
    if (e) exp_st[EV_VIOLATION] = 1'b1;
    src.attempt(k[1:0], q[4:0], a);
    chk({30'h0, a}, e ? 32'h1 : 32'h2);
  endtask

  // status word and interrupt level
  task automatic irq_chk();
    repeat (2) @(posedge hclk);
    rdchk({20'h0, IRQ_BASE, OFS_STATUS}, {29'h0, exp_st});
    chk({31'h0, irq}, {31'h0, |(exp_st & exp_mask)});
  endtask

  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    failures = 0;
    n_checks = 0;
    seed = 78;
    exp_st = 3'h0;
    exp_mask = 3'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, both words of a group alike
    for (int k = 0; k < 3; k++) begin
      exp_p[k] = reset_of(k);
      grp_chk(k);
    end
    rdchk({20'h0, IRQ_BASE, OFS_MASK}, 32'h0);
    wr({20'h0, IRQ_BASE, OFS_MASK}, 32'h7);
    exp_mask = 3'h7;
    // every named bit: protect, attempt at once, unprotect, attempt again
    for (int k = 0; k < 3; k++) begin
      v = valid_of(k);
      for (int b = 1; b < 32; b++) begin
        if (v[b]) begin
          grp_wr(k, 1'b1, 2'b00, 3'h2, 32'h1 << b);
          try(k, b);
          grp_wr(k, 1'b0, 2'b00, 3'h2, 32'h1 << b);
          try(k, b);
        end
      end
      grp_wr(k, 1'b1, 2'b00, 3'h2, ~v);
      grp_chk(k);
    end
    try(3, 5);
    irq_chk();
    // random widths, lanes and data
    for (int i = 0; i < 80; i++) begin
      g = {$random(seed)} % 3;
      s = {$random(seed)} % 3;
      lo = $random(seed);
      if (s == 3'h2) lo = 2'b00;
      if (s == 3'h1) lo[0] = 1'b0;
      grp_wr(g, $random(seed), lo, s, $random(seed));
      grp_chk(g);
      p = {$random(seed)} % 20;
      v = valid_of(g);
      if (v[p]) try(g, p);
    end
    irq_chk();
    // masking, then write-one-to-clear of the status
    wr({20'h0, IRQ_BASE, OFS_MASK}, 32'h0);
    exp_mask = 3'h0;
    irq_chk();
    wr({20'h0, IRQ_BASE, OFS_STATUS}, 32'h7);
    exp_st = 3'h0;
    wr({20'h0, IRQ_BASE, OFS_MASK}, 32'h4);
    exp_mask = 3'h4;
    irq_chk();
    // a repeated unprotect raises the unmasked event
    grp_wr(0, 1'b0, 2'b00, 3'h2, 32'h2);
    grp_wr(0, 1'b0, 2'b00, 3'h2, 32'h2);
    irq_chk();
    // unmapped place reads zero and ignores writes
    wr(32'h00000400, 32'hffffffff);
    rdchk(32'h00000400, 32'h0);
    end_sim();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule

// ===== write_filter.sv
`timescale 1ns/1ps
module write_filter (
  input wire logic hclk,
  input wire logic hresetn,
  input guard_pkg::per_req_t req,
  input wire logic [31:0] prot0,
  input wire logic [31:0] prot1,
  input wire logic [31:0] prot2,
  output guard_pkg::per_ans_t ans
);
  import guard_pkg::*;

  per_ans_t s_r; // registered answer
  per_ans_t s_nxt; // next answer
  logic hit; // target is protected

  ////////////////////////////////////////////////////////////////////////////
  // look up the target bit against the current protection state
  always_comb begin
    case (req.grp)
      2'd0: hit = prot0[req.pos];
      2'd1: hit = prot1[req.pos];
      2'd2: hit = prot2[req.pos];
      default: hit = 1'b0; // no group here, nothing to guard
    endcase
    s_nxt.ok = req.req & ~hit;
    s_nxt.err = req.req & hit;
  end

  // answer register, one cycle after the attempt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{ok: 1'b0, err: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ans = s_r;
endmodule
